// >>> rtl/sfp_dev.sv
`timescale 1ns/1ps
module sfp_dev
	import sfp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	sfp_if.dev link,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_rd_data,
	input wire logic mem_busy,
	output logic wr_byte_valid,
	output logic [7:0] wr_byte,
	output logic op_valid,
	output logic op_reject,
	output logic [7:0] op_code,
	output logic [ADDR_W-1:0] op_lo,
	output logic [ADDR_W-1:0] op_hi,
	output logic write_enable_latch,
	output logic quad_enable,
	output logic deep_pd
);
	logic sclk_ff1, sclk_s, sclk_q, cs_ff1, cs_s, cs_q;
	logic [3:0] io_ff1, io_s;
	logic paused, blocked, rst_armed, bad;
	logic [4:0] block_protect_bits;
	logic protect_complement, status_protect_hi, status_protect_lo;
	sfp_phase_type phase;
	logic [5:0] bitcnt, bitcnt_next;
	logic [3:0] dcnt;
	logic [2:0] dbit, ocnt;
	logic [1:0] nbytes;
	logic [31:0] sr, sr_next;
	logic [7:0] op, in1, in2, osr, cur, src;
	logic [ADDR_W-1:0] addr, a_mask, a_lo, a_hi, prot_lo, prot_hi;
	logic prot_none, drive_en, hit, sr_locked;
	logic [2:0] lanes_in, lo_l;
	logic [3:0] in_bits, out_bits, lane_mask, ocnt_sum;
	sfp_fmt_type fmt, nf;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sclk_ff1 <= 1'b0;
			sclk_s <= 1'b0;
			sclk_q <= 1'b0;
			cs_ff1 <= 1'b1;
			cs_s <= 1'b1;
			cs_q <= 1'b1;
			io_ff1 <= 4'hf;
			io_s <= 4'hf;
		end else begin
			sclk_ff1 <= link.sclk;
			sclk_s <= sclk_ff1;
			sclk_q <= sclk_s;
			cs_ff1 <= link.cs_n;
			cs_s <= cs_ff1;
			cs_q <= cs_s;
			io_ff1 <= link.io;
			io_s <= io_ff1;
		end
	end

	// either idle clock level works: only edges inside a frame count
	wire rise = sclk_s & ~sclk_q;
	wire fall = ~sclk_s & sclk_q;
	wire cs_rise = cs_s & ~cs_q;
	wire abort = cs_rise & paused;
	wire act = ~cs_s & ~blocked & ~paused;
	wire rx = act & rise;
	wire tx = act & fall;
	wire launch = tx && phase == PH_DATA && fmt.is_read && !bad;

	// pause only steers the serial side; mem_busy work runs on untouched
	always_ff @(posedge ref_clk) begin
		if (sys_rst || cs_s || quad_enable) begin
			paused <= 1'b0;
		end else if (!paused && !io_s[3] && !sclk_s) begin
			paused <= 1'b1;
		end else if (paused && io_s[3] && !sclk_s) begin
			paused <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			blocked <= 1'b0;
		end else if (abort) begin
			blocked <= 1'b1;
		end else if (cs_s && io_s[3]) begin
			blocked <= 1'b0;
		end
	end

	always_comb begin
		fmt = sfp_fmt(op);
		lanes_in = (phase == PH_ADDR) ? fmt.addr_lanes : LANE1;
		case (lanes_in)
			LANE2: in_bits = {2'b00, io_s[1:0]};
			LANE4: in_bits = io_s;
			default: in_bits = {3'b000, io_s[0]};
		endcase
		sr_next = (sr << lanes_in) | {28'h0000000, in_bits};
		bitcnt_next = bitcnt + {3'b000, lanes_in};
		nf = sfp_fmt(sr_next[7:0]);
	end

	always_ff @(posedge ref_clk) begin
		wr_byte_valid <= 1'b0;
		if (sys_rst) begin
			phase <= PH_OPC;
			bitcnt <= '0;
			dcnt <= '0;
			dbit <= '0;
			nbytes <= '0;
			sr <= '0;
			op <= '0;
			bad <= 1'b0;
			addr <= '0;
			in1 <= '0;
			in2 <= '0;
			wr_byte <= '0;
		end else if (cs_s) begin
			phase <= PH_OPC;
			bitcnt <= '0;
			dcnt <= '0;
			dbit <= '0;
			nbytes <= '0;
		end else if (rx) begin
			sr <= sr_next;
			case (phase)
				PH_OPC: begin
					bitcnt <= bitcnt_next;
					if (bitcnt == OPC_LAST) begin
						op <= sr_next[7:0];
						bad <= (nf.quad && !quad_enable) || (deep_pd
							&& sr_next[7:0] != OP_RELEASE_PD && sr_next[7:0] != OP_RST_EN
							&& sr_next[7:0] != OP_RST);
						phase <= nf.has_addr ? PH_ADDR : PH_DATA;
					end
				end
				PH_ADDR: begin
					bitcnt <= bitcnt_next;
					if (bitcnt_next == ADDR_END) begin
						addr <= sr_next[ADDR_W-1:0];
						phase <= (fmt.dummy != 4'h0) ? PH_DUMMY : PH_DATA;
					end
				end
				PH_DUMMY: begin
					dcnt <= dcnt + 4'h1;
					if (dcnt == fmt.dummy - 4'h1) begin
						phase <= PH_DATA;
					end
				end
				PH_DATA: begin
					if (!fmt.is_read) begin
						dbit <= dbit + 3'h1;
						if (dbit == 3'h7) begin
							wr_byte <= sr_next[7:0];
							wr_byte_valid <= (op == OP_PAGE_PROG) && write_enable_latch && !bad;
							if (nbytes == 2'h0) begin
								in1 <= sr_next[7:0];
							end else if (nbytes == 2'h1) begin
								in2 <= sr_next[7:0];
							end
							if (nbytes != 2'h3) begin
								nbytes <= nbytes + 2'h1;
							end
						end
					end
				end
				default: phase <= PH_OPC;
			endcase
		end
	end

	always_comb begin
		lo_l = fmt.data_lanes;
		if (op == OP_RD_SR1) begin
			src = {status_protect_lo, block_protect_bits, write_enable_latch, mem_busy};
		end else if (op == OP_RD_SR2) begin
			src = {1'b0, protect_complement, 4'h0, quad_enable, status_protect_hi};
		end else begin
			src = mem_rd_data;
		end
		cur = (ocnt == 3'h0) ? src : osr;
		ocnt_sum = {1'b0, ocnt} + {1'b0, lo_l};
		case (lo_l)
			LANE2: begin
				out_bits = {2'b00, cur[7:6]};
				lane_mask = 4'h3;
			end
			LANE4: begin
				out_bits = cur[7:4];
				lane_mask = 4'hf;
			end
			default: begin
				out_bits = {2'b00, cur[7], 1'b0};
				lane_mask = 4'h2;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			link.dev_o <= 4'h0;
			link.dev_oe <= 4'h0;
			drive_en <= 1'b0;
			osr <= '0;
			ocnt <= '0;
			mem_addr <= '0;
		end else begin
			// enable with the first bit, else the far end samples a floating lane
			link.dev_oe <= ((drive_en && act) || launch) ? lane_mask : 4'h0;
			if (cs_s) begin
				drive_en <= 1'b0;
				ocnt <= '0;
			end else if (rx && phase == PH_ADDR && bitcnt_next == ADDR_END) begin
				mem_addr <= sr_next[ADDR_W-1:0];
			end else if (launch) begin
				drive_en <= 1'b1;
				link.dev_o <= out_bits;
				osr <= cur << lo_l;
				ocnt <= ocnt_sum[2:0];
				if (ocnt_sum[3]) begin
					mem_addr <= mem_addr + 23'h000001;
				end
			end
		end
	end

	sfp_prot_map u_map (
		.block_protect_bits(block_protect_bits),
		.protect_complement(protect_complement),
		.prot_none(prot_none),
		.prot_lo(prot_lo),
		.prot_hi(prot_hi)
	);

	always_comb begin
		case (op)
			OP_PAGE_PROG: a_mask = PAGE_MASK;
			OP_SECT_ERASE: a_mask = SECT_MASK;
			OP_BLK32_ERASE: a_mask = BLK32_MASK;
			OP_BLK64_ERASE: a_mask = BLK64_MASK;
			default: a_mask = ADDR_ALL;
		endcase
		a_lo = addr & ~a_mask;
		a_hi = addr | a_mask;
		hit = !prot_none && a_lo <= prot_hi && a_hi >= prot_lo;
		// the protect pin only counts while it is not a data lane
		sr_locked = status_protect_hi || (status_protect_lo && !io_s[2] && !quad_enable);
	end

	always_ff @(posedge ref_clk) begin
		op_valid <= 1'b0;
		op_reject <= 1'b0;
		if (sys_rst) begin
			write_enable_latch <= 1'b0;
			deep_pd <= 1'b0;
			rst_armed <= 1'b0;
			quad_enable <= QE_RESET;
			block_protect_bits <= BP_RESET;
			protect_complement <= CMP_RESET;
			status_protect_hi <= SRP_RESET;
			status_protect_lo <= SRP_RESET;
			op_code <= '0;
			op_lo <= '0;
			op_hi <= '0;
		end else if (cs_rise && !abort && !bad && bitcnt >= OPC_BITS) begin
			rst_armed <= (op == OP_RST_EN);
			case (op)
				OP_WRITE_ENABLE: if (bitcnt == OPC_BITS) write_enable_latch <= 1'b1;
				OP_WRITE_DISABLE: write_enable_latch <= 1'b0;
				OP_RST: begin
					if (rst_armed) begin
						write_enable_latch <= 1'b0;
						deep_pd <= 1'b0;
					end
				end
				OP_DEEP_PD: deep_pd <= 1'b1;
				OP_RELEASE_PD: deep_pd <= 1'b0;
				OP_WR_SR1, OP_WR_SR2: begin
					if (write_enable_latch && !mem_busy && nbytes != 2'h0) begin
						write_enable_latch <= 1'b0;
						if (!sr_locked) begin
							if (op == OP_WR_SR1) begin
								status_protect_lo <= in1[SR1_STATUS_PROTECT_LO];
								block_protect_bits <= in1[SR1_BP_HI:SR1_BP_LO];
							end
							if (op == OP_WR_SR2 || nbytes != 2'h1) begin
								protect_complement <= (op == OP_WR_SR2) ? in1[SR2_CMP] : in2[SR2_CMP];
								quad_enable <= (op == OP_WR_SR2) ? in1[SR2_QE] : in2[SR2_QE];
								status_protect_hi <= (op == OP_WR_SR2) ? in1[SR2_STATUS_PROTECT_HI] : in2[SR2_STATUS_PROTECT_HI];
							end
						end
					end
				end
				OP_PAGE_PROG, OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE,
				OP_CHIP_ERASE, OP_CHIP_ERASE_ALT: begin
					if (write_enable_latch && !mem_busy && (bitcnt == ADDR_END || !fmt.has_addr)) begin
						write_enable_latch <= 1'b0;
						op_code <= op;
						op_lo <= a_lo;
						op_hi <= a_hi;
						op_valid <= !hit;
						op_reject <= hit;
					end
				end
				default: begin
				end
			endcase
		end else if (cs_rise) begin
			rst_armed <= 1'b0;
		end
	end
endmodule

// >>> rtl/sfp_pkg.sv
// Behaviour
// - accept clock mode 0 and mode 3
// - sample on rising edge, launch on falling
// - two-lane reads use lanes 0 and 1
// - four-lane reads add lanes 2 and 3
// - four-lane commands need quad enable set
// - pause only works with quad enable clear
// - pause stops serial traffic, not internal work
// - pause starts at hold fall, clock low
// - pause ends at hold rise, clock low
// - paused: output released, input and clock ignored
// - select rise while paused resets interface
// - write enable command sets the latch
// - latch clears on reset, disable, writes, erases
// - protect pin low locks protect bits while status_protect_lo is set and quad enable clear
// - deep power-down ignores all but release, reset
// - protected range readable, never programmed or erased
// - upper bits 00: top fractions protected
// - upper bits 01: bottom fractions protected
// - upper bits 10: top small sizes protected
// - upper bits 11: bottom small sizes protected
// - low code 111 all, 000 nothing
// - complement bit inverts the protected region
// - protect and complement bits persist, complement 0
package sfp_pkg;
	localparam int ADDR_W = 23;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_RD_SR1 = 8'h05;
	localparam logic [7:0] OP_RD_SR2 = 8'h35;
	localparam logic [7:0] OP_WR_SR1 = 8'h01;
	localparam logic [7:0] OP_WR_SR2 = 8'h31;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
	localparam logic [7:0] OP_DEEP_PD = 8'hb9;
	localparam logic [7:0] OP_RELEASE_PD = 8'hab;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	// status field positions
	localparam int SR1_STATUS_PROTECT_LO = 7;
	localparam int SR1_BP_HI = 6;
	localparam int SR1_BP_LO = 2;
	localparam int SR1_WEL = 1;
	localparam int SR1_WIP = 0;
	localparam int SR2_CMP = 6;
	localparam int SR2_QE = 1;
	localparam int SR2_STATUS_PROTECT_HI = 0;
	localparam logic [4:0] BP_RESET = 5'h00;
	localparam logic CMP_RESET = 1'b0;
	localparam logic QE_RESET = 1'b0;
	localparam logic SRP_RESET = 1'b0;
	// operation footprints, as address masks
	localparam logic [ADDR_W-1:0] PAGE_MASK = 23'h0000ff;
	localparam logic [ADDR_W-1:0] SECT_MASK = 23'h000fff;
	localparam logic [ADDR_W-1:0] BLK32_MASK = 23'h007fff;
	localparam logic [ADDR_W-1:0] BLK64_MASK = 23'h00ffff;
	localparam logic [ADDR_W-1:0] ADDR_ALL = 23'h7fffff;
	// log2 of protected sizes
	localparam logic [4:0] SH_LARGE_BASE = 5'h10;
	localparam logic [4:0] SH_SMALL_BASE = 5'h0b;
	localparam logic [4:0] SH_SMALL_MAX = 5'h0f;
	localparam logic [2:0] CODE_SMALL_CAP = 3'h4;
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_ALL = 3'h7;
	// wire framing
	localparam logic [5:0] OPC_LAST = 6'h07;
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_END = 6'h20;
	localparam logic [2:0] LANE1 = 3'h1;
	localparam logic [2:0] LANE2 = 3'h2;
	localparam logic [2:0] LANE4 = 3'h4;
	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
	localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
	// host serial clock
	localparam int REF_PERIOD_NS = 8;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int SCLK_HALF_MIN = 6;

	typedef enum logic [1:0] {
		PH_OPC = 2'b00,
		PH_ADDR = 2'b01,
		PH_DUMMY = 2'b11,
		PH_DATA = 2'b10
	} sfp_phase_type;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_RUN = 2'b01,
		H_END = 2'b11,
		H_GAP = 2'b10
	} sfp_host_state_type;

	typedef struct packed {
		logic has_addr;
		logic is_read;
		logic quad;
		logic [2:0] addr_lanes;
		logic [2:0] data_lanes;
		logic [3:0] dummy;
	} sfp_fmt_type;

	function automatic sfp_fmt_type sfp_fmt(input logic [7:0] op);
		sfp_fmt_type f;
		f = '{has_addr: 1'b0, is_read: 1'b0, quad: 1'b0, addr_lanes: LANE1,
			data_lanes: LANE1, dummy: 4'h0};
		case (op)
			OP_READ: begin
				f.has_addr = 1'b1;
				f.is_read = 1'b1;
			end
			OP_FAST_READ, OP_DUAL_OUT, OP_QUAD_OUT: begin
				f.has_addr = 1'b1;
				f.is_read = 1'b1;
				f.dummy = DUMMY_FAST;
				f.data_lanes = (op == OP_DUAL_OUT) ? LANE2 : (op == OP_QUAD_OUT) ? LANE4 : LANE1;
				f.quad = (op == OP_QUAD_OUT);
			end
			OP_DUAL_IO: begin
				f = '{1'b1, 1'b1, 1'b0, LANE2, LANE2, DUMMY_DUAL_IO};
			end
			OP_QUAD_IO: begin
				f = '{1'b1, 1'b1, 1'b1, LANE4, LANE4, DUMMY_QUAD_IO};
			end
			OP_RD_SR1, OP_RD_SR2: begin
				f.is_read = 1'b1;
			end
			OP_PAGE_PROG, OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE: begin
				f.has_addr = 1'b1;
			end
			default: begin
			end
		endcase
		return f;
	endfunction
endpackage

// >>> rtl/sfp_if.sv
`timescale 1ns/1ps
interface sfp_if;
	logic sclk;
	logic cs_n;
	logic [3:0] host_o;
	logic [3:0] host_oe;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic [3:0] io;
	// device wins a clash; undriven lanes float high as with pull-ups
	assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

	modport dev (input sclk, input cs_n, input io, output dev_o, output dev_oe);
	modport host (output sclk, output cs_n, output host_o, output host_oe, input io);
endinterface

// >>> rtl/sfp_prot_map.sv
`timescale 1ns/1ps
module sfp_prot_map
	import sfp_pkg::*;
(
	input wire logic [4:0] block_protect_bits,
	input wire logic protect_complement,
	output logic prot_none,
	output logic [ADDR_W-1:0] prot_lo,
	output logic [ADDR_W-1:0] prot_hi
);
	logic [2:0] code;
	logic [4:0] sh;
	logic [ADDR_W-1:0] m;
	logic bottom;

	always_comb begin
		code = block_protect_bits[2:0];
		bottom = block_protect_bits[3];
		if (block_protect_bits[4]) begin
			sh = (code >= CODE_SMALL_CAP) ? SH_SMALL_MAX : SH_SMALL_BASE + {2'b00, code};
		end else begin
			sh = SH_LARGE_BASE + {2'b00, code};
		end
		m = ADDR_ALL >> (5'(ADDR_W) - sh);
		if (!protect_complement) begin
			prot_none = (code == CODE_NONE);
			if (code == CODE_ALL) begin
				prot_lo = '0;
				prot_hi = ADDR_ALL;
			end else if (bottom) begin
				prot_lo = '0;
				prot_hi = m;
			end else begin
				prot_lo = ~m;
				prot_hi = ADDR_ALL;
			end
		end else begin
			// every region touches one end, so its complement is one span too
			prot_none = (code == CODE_ALL);
			if (code == CODE_NONE) begin
				prot_lo = '0;
				prot_hi = ADDR_ALL;
			end else if (bottom) begin
				prot_lo = m + 23'h000001;
				prot_hi = ADDR_ALL;
			end else begin
				prot_lo = '0;
				prot_hi = ~m - 23'h000001;
			end
		end
	end
endmodule

// >>> rtl/sfp_host.sv
`timescale 1ns/1ps
module sfp_host
	import sfp_pkg::*;
#(
	parameter int SCLK_HALF = SCLK_HALF_CYC
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	sfp_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [1:0] cmd_wr_len,
	input wire logic [15:0] cmd_wr_data,
	input wire logic [7:0] cmd_rd_len,
	input wire logic hold_req,
	input wire logic wp_level,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic pausing
);
	if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > 255) begin : g_chk
		$error("SCLK_HALF too small for the device synchronisers");
	end

	sfp_host_state_type state;
	logic [7:0] hc;
	logic [11:0] ncl, c_addr, c_wr, c_dum, c_end;
	logic [47:0] tsr;
	logic [2:0] la, ld, txl;
	logic quad_cmd;
	logic [3:0] io_ff1, io_s, dbits, dmask, in_bits, rsum;
	logic [7:0] rsr, rsr_next;
	logic [2:0] rbit;
	sfp_fmt_type cf;

	wire tick = (hc == 8'(SCLK_HALF - 1));
	wire run_tick = tick && state == H_RUN && !pausing;

	always_comb begin
		cf = sfp_fmt(cmd_op);
		txl = (ncl < 12'd8) ? LANE1 : (ncl < c_addr) ? la : (ncl < c_wr) ? LANE1 : 3'h0;
		case (ld)
			LANE2: in_bits = {2'b00, io_s[1:0]};
			LANE4: in_bits = io_s;
			default: in_bits = {3'b000, io_s[1]};
		endcase
		rsr_next = (rsr << ld) | {4'h0, in_bits};
		rsum = {1'b0, rbit} + {1'b0, ld};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			io_ff1 <= 4'hf;
			io_s <= 4'hf;
		end else begin
			io_ff1 <= link.io;
			io_s <= io_ff1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || state == H_IDLE) begin
			pausing <= 1'b0;
		end else if (!link.sclk && !quad_cmd && !tick && (ncl < c_wr || !hold_req)) begin
			// no entry while reading: the bit after resuming would reach us too late
			pausing <= hold_req;
		end
	end

	always_ff @(posedge ref_clk) begin
		done <= 1'b0;
		if (sys_rst) begin
			state <= H_IDLE;
			hc <= '0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			cmd_ready <= 1'b0;
			ncl <= '0;
			{c_addr, c_wr, c_dum, c_end} <= '0;
			la <= LANE1;
			ld <= LANE1;
			quad_cmd <= 1'b0;
		end else begin
			hc <= (tick || state == H_IDLE || pausing) ? 8'h00 : hc + 8'h01;
			case (state)
				H_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						link.cs_n <= 1'b0;
						ncl <= '0;
						la <= cf.addr_lanes;
						ld <= cf.data_lanes;
						quad_cmd <= cf.quad;
						c_addr <= 12'd8 + (cf.has_addr ? 12'(6'd24 / cf.addr_lanes) : 12'd0);
						c_wr <= 12'd8 + (cf.has_addr ? 12'(6'd24 / cf.addr_lanes) : 12'd0)
							+ {7'h00, cmd_wr_len, 3'h0};
						c_dum <= 12'd8 + (cf.has_addr ? 12'(6'd24 / cf.addr_lanes) : 12'd0)
							+ {7'h00, cmd_wr_len, 3'h0} + {8'h00, cf.dummy};
						c_end <= 12'd8 + (cf.has_addr ? 12'(6'd24 / cf.addr_lanes) : 12'd0)
							+ {7'h00, cmd_wr_len, 3'h0} + {8'h00, cf.dummy}
							+ 12'({cmd_rd_len, 3'h0} / cf.data_lanes);
						state <= H_RUN;
					end
				end
				H_RUN: begin
					if (run_tick) begin
						link.sclk <= ~link.sclk;
						if (!link.sclk) begin
							ncl <= ncl + 12'h001;
						end else if (ncl == c_end) begin
							state <= H_END;
						end
					end
				end
				H_END: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						state <= H_GAP;
					end
				end
				H_GAP: begin
					if (tick) begin
						done <= 1'b1;
						state <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// bits are presented at select fall and at every falling edge after but the last
	wire present = (state == H_IDLE && cmd_valid && cmd_ready)
		|| (run_tick && link.sclk && ncl != c_end);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tsr <= '0;
			dbits <= 4'h0;
			dmask <= 4'h0;
		end else if (state == H_IDLE && cmd_valid && cmd_ready) begin
			// without an address field the write bytes follow the opcode directly
			tsr <= cf.has_addr ? {cmd_op[6:0], 1'b0, cmd_addr, cmd_wr_data, 1'b0}
				: {cmd_op[6:0], cmd_wr_data, 25'h0000000};
			dbits <= {3'b000, cmd_op[7]};
			dmask <= 4'h1;
		end else if (present) begin
			case (txl)
				LANE1: begin
					dbits <= {3'b000, tsr[47]};
					dmask <= 4'h1;
				end
				LANE2: begin
					dbits <= {2'b00, tsr[47:46]};
					dmask <= 4'h3;
				end
				LANE4: begin
					dbits <= tsr[47:44];
					dmask <= 4'hf;
				end
				default: begin
					dbits <= 4'h0;
					dmask <= 4'h0;
				end
			endcase
			tsr <= tsr << txl;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			link.host_o <= 4'hf;
			link.host_oe <= 4'h0;
		end else if (quad_cmd && state != H_IDLE) begin
			link.host_o <= dbits;
			link.host_oe <= dmask;
		end else begin
			link.host_o <= {~pausing, wp_level, dbits[1:0]};
			link.host_oe <= {2'b11, dmask[1:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_valid <= 1'b0;
		if (sys_rst || state == H_IDLE) begin
			rsr <= '0;
			rbit <= '0;
			if (sys_rst) begin
				rd_data <= '0;
			end
		end else if (run_tick && !link.sclk && ncl >= c_dum && ncl < c_end) begin
			rsr <= rsr_next;
			rbit <= rsum[2:0];
			if (rsum[3]) begin
				rd_data <= rsr_next;
				rd_valid <= 1'b1;
			end
		end
	end
endmodule

// >>> tb/sfp_sva.sv
`timescale 1ns/1ps
module sfp_sva (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// the host clock stands low between frames, mode 0 framing
	chk_idle_clk_low: assert property (cs_n |-> !sclk)
		else $error("serial clock moved while deselected");
	chk_select_fall: assert property ($fell(cs_n) |-> !sclk)
		else $error("select fell with clock high");
	chk_select_rise: assert property ($rose(cs_n) |-> !sclk && !$past(sclk, 5))
		else $error("select rose too soon after last clock");
	// halves are six ref clocks in this bench
	chk_high_half: assert property ($rose(sclk) |=> sclk [*5])
		else $error("serial clock high half too short");
	chk_low_half: assert property ($fell(sclk) |=> !sclk [*5])
		else $error("serial clock low half too short");
	chk_out_stable: assert property (sclk && $past(sclk, 4) |-> $stable(dev_o))
		else $error("device output changed while clock high");
	chk_oe_on_low: assert property ($rose(dev_oe[1]) |-> !sclk)
		else $error("device began driving with clock high");
	chk_release_lanes: assert property (dev_oe != 4'h0 |-> !cs_n || !$past(cs_n, 5))
		else $error("device kept driving after deselect");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import sfp_pkg::*;
;
	logic ref_clk, sys_rst, cmd_valid, cmd_ready, rd_valid, done;
	logic [7:0] cmd_op, cmd_rd_len, rd_data, mem_rd_data, op_code;
	logic [22:0] cmd_addr, mem_addr, op_lo, op_hi, a;
	logic [1:0] cmd_wr_len;
	logic [15:0] cmd_wr_data;
	logic op_valid, op_reject, write_enable_latch, quad_enable, deep_pd, hold_req, pausing;
	logic [7:0] rq[$];
	logic [23:0] oq[$];
	logic [23:0] note;
	int errors, num_checks;
	sfp_if link();
	sfp_host #(.SCLK_HALF(6)) sfp_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_wr_len(cmd_wr_len), .cmd_wr_data(cmd_wr_data), .cmd_rd_len(cmd_rd_len),
		.hold_req(hold_req), .wp_level(1'b1), .rd_valid(rd_valid), .rd_data(rd_data),
		.done(done), .pausing(pausing));
	sfp_dev sfp_dev_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .mem_addr(mem_addr),
		.mem_rd_data(mem_rd_data), .mem_busy(1'b0), .wr_byte_valid(), .wr_byte(),
		.op_valid(op_valid), .op_reject(op_reject), .op_code(op_code), .op_lo(op_lo),
		.op_hi(op_hi), .write_enable_latch(write_enable_latch), .quad_enable(quad_enable),
		.deep_pd(deep_pd));
	sfp_sva sfp_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(link.sclk),
		.cs_n(link.cs_n), .dev_o(link.dev_o), .dev_oe(link.dev_oe));
	// array contents are a pattern of the address, so every byte is predictable
	function automatic logic [7:0] pat(input logic [22:0] x);
		return x[7:0] ^ x[15:8];
	endfunction
	assign mem_rd_data = pat(mem_addr);
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [22:0] ad, input logic [1:0] wl,
			input logic [15:0] wd, input logic [7:0] rl);
		@(negedge ref_clk);
		{cmd_op, cmd_addr, cmd_wr_len, cmd_wr_data, cmd_rd_len} = {op, ad, wl, wd, rl};
		cmd_valid = 1'b1;
		// ready is a level: seen at a falling edge, the next rising edge takes us
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic op1(input logic [7:0] op);
		cmd(op, '0, '0, '0, '0);
	endtask
	task automatic sw(input logic [4:0] bp, input logic c, input logic q);
		op1(OP_WRITE_ENABLE);
		cmd(OP_WR_SR1, '0, 2'h2, {1'b0, bp, 2'b00, 1'b0, c, 4'h0, q, 1'b0}, '0);
	endtask
	// a sector erase after setting the protect code, with its expected verdict
	task automatic pe(input logic [4:0] bp, input logic c, input logic [22:0] ad, input logic r);
		sw(bp, c, 1'b0);
		op1(OP_WRITE_ENABLE);
		oq.push_back({r, ad & 23'h7ff000});
		cmd(OP_SECT_ERASE, ad, '0, '0, '0);
		chk("latch", 24'h0, write_enable_latch);
	endtask
	task automatic rd(input logic [7:0] op, input logic e);
		a = 23'($urandom) & 23'h7ffff0;
		rq.push_back(e ? pat(a) : 8'hff);
		rq.push_back(e ? pat(a + 23'h1) : 8'hff);
		cmd(op, a, '0, '0, 8'h2);
	endtask
	always @(negedge ref_clk) begin
		if (rd_valid === 1'b1) chk("rd_data", rq.pop_front(), rd_data);
		if ((op_valid | op_reject) === 1'b1) begin
			note = oq.pop_front();
			chk("op", note, {op_reject, op_lo});
			chk("op_hi", {1'b0, note[22:0] | SECT_MASK}, {1'b0, op_hi});
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		conclude();
	end
	initial begin
		{hold_req, sys_rst, cmd_valid, cmd_op, cmd_addr, cmd_wr_len, cmd_wr_data, cmd_rd_len} = '0;
		sys_rst = 1'b1;
		errors = 0;
		num_checks = 0;
		void'($urandom(77));
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		op1(OP_WRITE_ENABLE);
		chk("latch", 24'h1, write_enable_latch);
		op1(OP_WRITE_DISABLE);
		chk("latch", 24'h0, write_enable_latch);
		op1(OP_DEEP_PD);
		chk("deep_pd", 24'h1, deep_pd);
		op1(OP_WRITE_ENABLE);
		chk("latch", 24'h0, write_enable_latch);
		op1(OP_RELEASE_PD);
		op1(OP_WRITE_ENABLE);
		chk("latch", 24'h1, write_enable_latch);
		op1(OP_RST_EN);
		op1(OP_RST);
		chk("latch", 24'h0, write_enable_latch);
		rd(OP_READ, 1);
		rd(OP_FAST_READ, 1);
		rd(OP_DUAL_OUT, 1);
		rd(OP_DUAL_IO, 1);
		// without quad enable the device stays silent and pull-ups read back
		rd(OP_QUAD_OUT, 0);
		sw(5'h00, 1'b0, 1'b1);
		chk("quad_enable", 24'h1, quad_enable);
		rd(OP_QUAD_OUT, 1);
		rd(OP_QUAD_IO, 1);
		pe(5'h01, 1'b0, 23'h7e0000, 1);
		pe(5'h01, 1'b0, 23'h7d0000, 0);
		pe(5'h09, 1'b0, 23'h01f000, 1);
		pe(5'h11, 1'b0, 23'h7fe000, 0);
		pe(5'h15, 1'b0, 23'h7f8000, 1);
		pe(5'h19, 1'b0, 23'h001000, 0);
		pe(5'h07, 1'b0, 23'h000000, 1);
		pe(5'h01, 1'b1, 23'h7e0000, 0);
		pe(5'h01, 1'b1, 23'h7d0000, 1);
		pe(5'h00, 1'b1, 23'h123000, 1);
		// a pause in mid-address must freeze the frame without spoiling it
		op1(OP_WRITE_ENABLE);
		oq.push_back({1'b1, 23'h7e0000});
		fork
			cmd(OP_SECT_ERASE, 23'h7e0000, '0, '0, '0);
			begin
				repeat (200) @(negedge ref_clk);
				hold_req = 1'b1;
				repeat (100) @(negedge ref_clk);
				chk("pausing", 24'h1, pausing);
				hold_req = 1'b0;
			end
		join
		chk("latch", 24'h0, write_enable_latch);
		repeat (20) @(posedge ref_clk);
		conclude();
	end
endmodule
